// ### fcl_loader.sv
// Register window, flash sequencer and direct loader for the logic array
// Operation
// - Decode 2M board window, loader inside
// - Unused addresses and upper lanes read zero
// - Accept 32, 16, 8 bit little-endian accesses
// - Low address lines ignored; registers repeat per slot
// - Autoload from flash after power-up
// - Halt bit stops autoload from flash
// - Control bit 2, written with halt bit 0 set, clears array configuration
// - Busy bit 7 shows flash busy
// - Full erase command, about 14 s busy
// - Address increments after each program completes
// - Program command writes byte, 9 us busy
// - Clearing halt restarts load from flash
// - Status bit 0 shows configuration done
// - Each data write passes one byte
// - Done rises right after last direct byte
// - Direct image lost; reset reloads from flash
// - Write protect blocks flash and EEPROM writes
// - Clear complete low while clearing
// - Data write during autoload fails configuration
// - Flash reads busy while halt is zero
`timescale 1ns/10ps
`default_nettype none
module fcl_loader
  import fcl_pkg::*;
#(
  parameter logic [31:0] PROG_COUNT = 32'(PROG_CYC),
  parameter logic [31:0] SECT_COUNT = 32'(SECT_CYC),
  parameter logic [31:0] CHIP_COUNT = 32'(CHIP_CYC)
) (
  // Clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    srst_in,
  // Board memory window access
  input  wire logic                    bar_hit_in,
  input  wire logic [WIN_ADDR_W-1:0]   addr_in,
  input  wire logic [3:0]              be_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  input  wire logic [31:0]             wdata_in,
  output logic [31:0]                  rdata_out,
  output logic                         rd_valid_out,
  // Configuration flash chip
  output logic                         flash_strobe_out,
  output fcl_op_e                      flash_op_out,
  output logic [FLASH_ADDR_W-1:0]      flash_addr_out,
  output logic [7:0]                   flash_wdata_out,
  input  wire logic [7:0]              flash_rdata_in,
  input  wire logic                    flash_dq5_in,
  // Logic array configuration port
  output logic                         autoload_en_out,
  output logic                         cfg_clear_out,
  output logic                         cfg_byte_valid_out,
  output logic [7:0]                   cfg_byte_out,
  output logic                         cfg_abort_out,
  input  wire logic                    cfg_done_in,
  input  wire logic                    cfg_init_in,
  // Board controls
  input  wire logic                    wp_in,
  output logic                         eeprom_wr_en_out,
  output logic                         bus_hold_sel_out
);

  logic                    region_hit;
  logic [3:0]              slot;
  logic                    wr_lo;
  logic                    rd_hit;
  logic                    go;
  logic                    halt_r;
  logic                    busy_bit;
  logic                    cmd_idle;
  logic                    start_prog;
  logic                    start_sect;
  logic                    start_chip;
  logic                    start_any;
  logic                    tmr_busy;
  logic                    tmr_done;
  logic [31:0]             tmr_count;
  logic [7:0]              rd_byte;
  logic [31:0]             rdata_nxt;
  fcl_state_e              state_r;
  fcl_op_e                 cur_op_r;

  if (PROG_COUNT == 32'h0 || SECT_COUNT == 32'h0 ||
      CHIP_COUNT == 32'h0) begin : g_count_chk
    $error("fcl_loader: operation counts must be nonzero");
  end

  function automatic logic at(input logic [14:0] ofs, input logic [3:0] s);
    at = (s == ofs[SLOT_MSB:SLOT_LSB]);
  endfunction

  // Window decode; bits below the slot field are not looked at
  assign region_hit = bar_hit_in &&
                      (addr_in[WIN_ADDR_W-1:REGION_LSB] == '0);
  assign slot       = addr_in[SLOT_MSB:SLOT_LSB];
  assign wr_lo      = wr_in && region_hit && be_in[0];
  assign rd_hit     = rd_in && bar_hit_in;
  assign go         = wdata_in[CMD_GO_BIT];

  // Busy while an operation runs or while autoload owns the flash
  assign busy_bit   = tmr_busy || (state_r != FCL_IDLE) || !halt_r;
  assign cmd_idle   = !busy_bit;
  assign start_prog = wr_lo && go && at(OFS_FLASH_PROGRAM, slot) &&
                      cmd_idle && !wp_in;
  assign start_sect = wr_lo && go && at(OFS_FLASH_SECT_ERS, slot) &&
                      cmd_idle && !wp_in;
  assign start_chip = wr_lo && go && at(OFS_FLASH_FULL_ERS, slot) &&
                      cmd_idle && !wp_in;
  assign start_any  = start_prog || start_sect || start_chip;
  assign tmr_count  = start_prog ? PROG_COUNT :
                      start_sect ? SECT_COUNT : CHIP_COUNT;

  fcl_op_timer #(
    .CNT_W      (32)
  ) u_timer (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .start_in   (start_any),
    .count_in   (tmr_count),
    .busy_out   (tmr_busy),
    .done_out   (tmr_done)
  );

  // Control register; reset leaves autoload running
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      halt_r           <= CTL_HALT_RST;
      bus_hold_sel_out <= CTL_HOLD_RST;
    end else if (wr_lo && at(OFS_LOAD_CONTROL, slot)) begin
      halt_r           <= wdata_in[CTL_HALT_BIT];
      bus_hold_sel_out <= wdata_in[CTL_HOLD_BIT];
    end
  end

  halt_write_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (wr_lo && at(OFS_LOAD_CONTROL, slot)) |=>
    (halt_r == $past(wdata_in[CTL_HALT_BIT])))
    else $error("halt bit write lost");

  // Array side controls
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      autoload_en_out    <= 1'b0;
      cfg_clear_out      <= 1'b0;
      cfg_byte_valid_out <= 1'b0;
      cfg_byte_out       <= 8'h00;
      cfg_abort_out      <= 1'b0;
      eeprom_wr_en_out   <= 1'b0;
    end else begin
      autoload_en_out    <= !halt_r;
      cfg_clear_out      <= wr_lo && at(OFS_LOAD_CONTROL, slot) &&
                            wdata_in[CTL_CLEAR_BIT] &&
                            wdata_in[CTL_HALT_BIT];
      cfg_byte_valid_out <= wr_lo && at(OFS_DIRECT_LOAD, slot);
      cfg_abort_out      <= wr_lo && at(OFS_DIRECT_LOAD, slot) &&
                            !halt_r;
      eeprom_wr_en_out   <= !wp_in;
      if (wr_lo && at(OFS_DIRECT_LOAD, slot)) begin
        cfg_byte_out <= wdata_in[7:0];
      end
    end
  end

  eeprom_lock_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    wp_in |=> !eeprom_wr_en_out)
    else $error("eeprom writable under write protect");

  // Flash data byte and address; increment wins over a late write
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      flash_addr_out  <= '0;
      flash_wdata_out <= 8'h00;
    end else begin
      if (wr_lo && at(OFS_FLASH_WRITE, slot)) begin
        flash_wdata_out <= wdata_in[7:0];
      end
      if (state_r == FCL_FIN && cur_op_r == FCL_OP_PROG) begin
        flash_addr_out <= flash_addr_out + FLASH_ADDR_W'(1);
      end else if (wr_lo && at(OFS_FLASH_ADDR_LOW, slot)) begin
        flash_addr_out[7:0] <= wdata_in[7:0];
      end else if (wr_lo && at(OFS_FLASH_ADDR_MID, slot)) begin
        flash_addr_out[15:8] <= wdata_in[7:0];
      end else if (wr_lo && at(OFS_FLASH_ADDR_HIGH, slot)) begin
        flash_addr_out[FLASH_ADDR_W-1:16] <= wdata_in[ADDR_HIGH_W-1:0];
      end
    end
  end

  // Flash sequencer
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_r  <= FCL_IDLE;
      cur_op_r <= FCL_OP_NONE;
    end else begin
      case (state_r)
        FCL_IDLE: begin
          if (start_any) begin
            state_r  <= FCL_RUN;
            cur_op_r <= start_prog ? FCL_OP_PROG :
                        start_sect ? FCL_OP_SECT : FCL_OP_CHIP;
          end
        end
        FCL_RUN: begin
          if (tmr_done) begin
            state_r <= FCL_FIN;
          end
        end
        FCL_FIN: begin
          state_r  <= FCL_IDLE;
          cur_op_r <= FCL_OP_NONE;
        end
        default: begin
          state_r <= FCL_IDLE;
        end
      endcase
    end
  end

  // One-cycle strobe to the flash chip with its operation code
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      flash_strobe_out <= 1'b0;
      flash_op_out     <= FCL_OP_NONE;
    end else begin
      flash_strobe_out <= 1'b0;
      if (start_prog) begin
        flash_strobe_out <= 1'b1;
        flash_op_out     <= FCL_OP_PROG;
      end else if (start_sect) begin
        flash_strobe_out <= 1'b1;
        flash_op_out     <= FCL_OP_SECT;
      end else if (start_chip) begin
        flash_strobe_out <= 1'b1;
        flash_op_out     <= FCL_OP_CHIP;
      end else if (wr_lo && go && at(OFS_FLASH_RESET, slot) && cmd_idle) begin
        flash_strobe_out <= 1'b1;
        flash_op_out     <= FCL_OP_RESET;
      end else if (rd_in && region_hit && at(OFS_FLASH_READ, slot) &&
                   cmd_idle) begin
        flash_strobe_out <= 1'b1;
        flash_op_out     <= FCL_OP_READ;
      end
    end
  end

  prog_strobe_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    start_prog |=> (flash_strobe_out && flash_op_out == FCL_OP_PROG))
    else $error("program strobe missing");

  // Read mux; only the low byte lane carries data
  always_comb begin
    rd_byte = 8'h00;
    if (!region_hit) begin
      rd_byte = 8'h00;
    end else if (at(OFS_LOAD_STATUS, slot)) begin
      rd_byte[ST_DONE_BIT] = cfg_done_in;
      rd_byte[ST_INIT_BIT] = cfg_init_in;
    end else if (at(OFS_LOAD_CONTROL, slot)) begin
      rd_byte[CTL_HALT_BIT] = halt_r;
      rd_byte[CTL_HOLD_BIT] = bus_hold_sel_out;
    end else if (at(OFS_FLASH_ERROR, slot)) begin
      rd_byte[FE_DQ5_BIT] = flash_dq5_in;
    end else if (at(OFS_FLASH_BUSY, slot)) begin
      rd_byte[FB_BUSY_BIT] = busy_bit;
    end else if (at(OFS_FLASH_READ, slot)) begin
      rd_byte = flash_rdata_in;
    end
    rdata_nxt = {24'h000000, rd_byte};
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata_out    <= 32'h00000000;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_hit;
      rdata_out    <= rd_hit ? rdata_nxt : 32'h00000000;
    end
  end

  // Checks
  status_read_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (rd_hit && region_hit && at(OFS_LOAD_STATUS, slot)) |=>
    (rdata_out[ST_DONE_BIT] == $past(cfg_done_in) &&
     rdata_out[ST_INIT_BIT] == $past(cfg_init_in)))
    else $error("status read does not follow array");
  rd_answer_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    rd_hit |=> rd_valid_out)
    else $error("read not answered in one cycle");
  upper_zero_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    rd_valid_out |-> (rdata_out[31:8] == 24'h000000))
    else $error("upper lanes not zero");
  unmapped_zero_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (rd_hit && !region_hit) |=> (rdata_out == 32'h00000000))
    else $error("unmapped read not zero");
  halt_busy_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (!halt_r && rd_hit && region_hit && at(OFS_FLASH_BUSY, slot)) |=>
    (rdata_out[FB_BUSY_BIT] && !flash_strobe_out))
    else $error("flash not busy while autoload runs");
  busy_ignore_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (state_r == FCL_RUN && wr_lo) |=> !flash_strobe_out)
    else $error("command taken while busy");
  wp_block_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    wp_in |-> !start_any)
    else $error("flash write under write protect");
  addr_step_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (state_r == FCL_FIN && cur_op_r == FCL_OP_PROG) |=>
    (flash_addr_out == $past(flash_addr_out) + FLASH_ADDR_W'(1)))
    else $error("address not incremented after program");
  prog_time_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (start_prog && PROG_COUNT >= 32'd8) |=> tmr_busy [*8])
    else $error("program busy ended early");
  clear_pulse_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (wr_lo && at(OFS_LOAD_CONTROL, slot) && wdata_in[CTL_CLEAR_BIT] &&
     wdata_in[CTL_HALT_BIT]) |=> cfg_clear_out ##1 !cfg_clear_out)
    else $error("clear pulse wrong");
  direct_byte_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (wr_lo && at(OFS_DIRECT_LOAD, slot)) |=>
    (cfg_byte_valid_out && cfg_byte_out == $past(wdata_in[7:0])))
    else $error("direct byte not passed");
  abort_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (wr_lo && at(OFS_DIRECT_LOAD, slot) && !halt_r) |=> cfg_abort_out)
    else $error("no abort on write during autoload");
  autoload_a: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    $fell(halt_r) |-> ##1 autoload_en_out)
    else $error("autoload not restarted");

endmodule
`default_nettype wire

// ### fcl_pkg.sv
// Constants and types shared by the configuration flash loader
package fcl_pkg;

  // Clock rate in MHz
  localparam int unsigned CLK_MHZ = 250;

  // Board memory window is 2M bytes wide
  localparam int unsigned WIN_ADDR_W = 21;
  localparam int unsigned REGION_LSB = 15;
  localparam int unsigned SLOT_LSB   = 11;
  localparam int unsigned SLOT_MSB   = 14;

  // Byte offsets of the loader registers inside the window
  localparam logic [14:0] OFS_LOAD_STATUS     = 15'h0000;
  localparam logic [14:0] OFS_LOAD_CONTROL    = 15'h0800;
  localparam logic [14:0] OFS_DIRECT_LOAD     = 15'h1000;
  localparam logic [14:0] OFS_FLASH_ERROR     = 15'h2000;
  localparam logic [14:0] OFS_FLASH_BUSY      = 15'h2800;
  localparam logic [14:0] OFS_FLASH_READ      = 15'h3800;
  localparam logic [14:0] OFS_FLASH_RESET     = 15'h4000;
  localparam logic [14:0] OFS_FLASH_PROGRAM   = 15'h4800;
  localparam logic [14:0] OFS_FLASH_SECT_ERS  = 15'h5000;
  localparam logic [14:0] OFS_FLASH_FULL_ERS  = 15'h5800;
  localparam logic [14:0] OFS_FLASH_WRITE     = 15'h6000;
  localparam logic [14:0] OFS_FLASH_ADDR_LOW  = 15'h6800;
  localparam logic [14:0] OFS_FLASH_ADDR_MID  = 15'h7000;
  localparam logic [14:0] OFS_FLASH_ADDR_HIGH = 15'h7800;

  // Field positions
  localparam int unsigned CTL_HALT_BIT  = 0;
  localparam int unsigned CTL_CLEAR_BIT = 2;
  localparam int unsigned CTL_HOLD_BIT  = 7;
  localparam int unsigned ST_DONE_BIT   = 0;
  localparam int unsigned ST_INIT_BIT   = 1;
  localparam int unsigned FE_DQ5_BIT    = 5;
  localparam int unsigned FB_BUSY_BIT   = 7;
  localparam int unsigned CMD_GO_BIT    = 0;
  localparam int unsigned FLASH_ADDR_W  = 21;
  localparam int unsigned ADDR_HIGH_W   = 5;

  // Values after reset
  localparam logic CTL_HALT_RST = 1'b0;
  localparam logic CTL_HOLD_RST = 1'b0;

  // Flash operation times and their cycle counts
  localparam longint unsigned PROG_TIME_NS = 9000;
  localparam longint unsigned SECT_TIME_MS = 700;
  localparam longint unsigned CHIP_TIME_S  = 14;
  localparam longint unsigned PROG_CYC = PROG_TIME_NS * CLK_MHZ / 1000;
  localparam longint unsigned SECT_CYC = SECT_TIME_MS * CLK_MHZ * 1000;
  localparam longint unsigned CHIP_CYC = CHIP_TIME_S * CLK_MHZ * 1000000;

  // Flash sequencer states
  typedef enum logic [1:0] {
    FCL_IDLE = 2'b00,
    FCL_RUN  = 2'b01,
    FCL_FIN  = 2'b11
  } fcl_state_e;

  // Operations presented to the flash chip
  typedef enum logic [2:0] {
    FCL_OP_NONE  = 3'h0,
    FCL_OP_READ  = 3'h1,
    FCL_OP_RESET = 3'h2,
    FCL_OP_PROG  = 3'h3,
    FCL_OP_SECT  = 3'h4,
    FCL_OP_CHIP  = 3'h5
  } fcl_op_e;

endpackage

// ### fcl_op_timer.sv
// Down counter that times one flash operation
`timescale 1ns/10ps
`default_nettype none
module fcl_op_timer #(
  parameter int unsigned CNT_W = 32
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  // Control
  input  wire logic             start_in,
  input  wire logic [CNT_W-1:0] count_in,
  // Status
  output logic                  busy_out,
  output logic                  done_out
);

  logic [CNT_W-1:0] cnt_r;

  if (CNT_W < 2) begin : g_width_chk
    $error("fcl_op_timer: CNT_W too small");
  end

  // Zero counts are treated as one cycle
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cnt_r    <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_out) begin
        cnt_r    <= (count_in == '0) ? CNT_W'(1) : count_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (cnt_r <= CNT_W'(1)) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r - CNT_W'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### fcl_array_model.sv
// Behavioural logic array and flash data source facing the loader
`timescale 1ns/10ps
`default_nettype none
module fcl_array_model #(
  parameter int INIT_CYC = 10,
  parameter int LOAD_CYC = 30,
  parameter int IMG_LEN  = 4
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  // From the loader
  input  wire logic        autoload_en_in,
  input  wire logic        cfg_clear_in,
  input  wire logic        cfg_byte_valid_in,
  input  wire logic [20:0] flash_addr_in,
  // To the loader
  output logic             cfg_done_out,
  output logic             cfg_init_out,
  output logic [7:0]       flash_rdata_out
);
  int clr_cnt;
  int load_cnt;
  int n_bytes;

  // Flash answers with an address-derived pattern
  assign flash_rdata_out = flash_addr_in[7:0] ^ 8'h5a;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cfg_done_out <= 1'b0;
      cfg_init_out <= 1'b1;
      clr_cnt      <= 0;
      load_cnt     <= 0;
      n_bytes      <= 0;
    end else if (cfg_clear_in) begin
      cfg_done_out <= 1'b0;
      cfg_init_out <= 1'b0;
      clr_cnt      <= INIT_CYC;
      load_cnt     <= 0;
      n_bytes      <= 0;
    end else if (clr_cnt > 0) begin
      clr_cnt      <= clr_cnt - 1;
      cfg_init_out <= (clr_cnt == 1);
    end else if (cfg_byte_valid_in) begin
      n_bytes      <= n_bytes + 1;
      cfg_done_out <= cfg_done_out | (n_bytes == IMG_LEN - 1);
    end else if (autoload_en_in && !cfg_done_out) begin
      load_cnt     <= load_cnt + 1;
      cfg_done_out <= (load_cnt == LOAD_CYC - 1);
    end
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the configuration flash loader
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fcl_pkg::*;
  logic        ref_clk_in = 0, srst_in = 1, bar_hit_in = 0;
  logic        wr_in = 0, rd_in = 0, flash_dq5_in = 0, wp_in = 0;
  logic [20:0] addr_in = '0, flash_addr_out;
  logic [3:0]  be_in = 4'h1;
  logic [31:0] wdata_in = '0, rdata_out, last_rd, seed = 32'd30;
  logic [7:0]  flash_rdata_in, flash_wdata_out, cfg_byte_out;
  logic        rd_valid_out, flash_strobe_out, autoload_en_out;
  logic        cfg_clear_out, cfg_byte_valid_out, cfg_abort_out;
  logic        cfg_done_in, cfg_init_in, eeprom_wr_en_out, bus_hold_sel_out;
  logic        hit = 1;
  logic [5:0]  hi = '0;
  fcl_op_e     flash_op_out;
  logic [63:0] rq[$];
  logic [63:0] re;
  logic [31:0] fq[$];
  logic [8:0]  cq[$];
  int          n_errors = 0, num_checks = 0, cyc = 0;

  fcl_loader #(.PROG_COUNT(32'd20), .SECT_COUNT(32'd50),
    .CHIP_COUNT(32'd100)) dut (.ref_clk_in(ref_clk_in),
    .srst_in(srst_in), .bar_hit_in(bar_hit_in), .addr_in(addr_in),
    .be_in(be_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .rd_valid_out(rd_valid_out),
    .flash_strobe_out(flash_strobe_out), .flash_op_out(flash_op_out),
    .flash_addr_out(flash_addr_out), .flash_wdata_out(flash_wdata_out),
    .flash_rdata_in(flash_rdata_in), .flash_dq5_in(flash_dq5_in),
    .autoload_en_out(autoload_en_out), .cfg_clear_out(cfg_clear_out),
    .cfg_byte_valid_out(cfg_byte_valid_out), .cfg_byte_out(cfg_byte_out),
    .cfg_abort_out(cfg_abort_out), .cfg_done_in(cfg_done_in),
    .cfg_init_in(cfg_init_in), .wp_in(wp_in),
    .eeprom_wr_en_out(eeprom_wr_en_out),
    .bus_hold_sel_out(bus_hold_sel_out));

  fcl_array_model arr (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .autoload_en_in(autoload_en_out), .cfg_clear_in(cfg_clear_out),
    .cfg_byte_valid_in(cfg_byte_valid_out), .flash_addr_in(flash_addr_out),
    .cfg_done_out(cfg_done_in), .cfg_init_out(cfg_init_in),
    .flash_rdata_out(flash_rdata_in));

  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [31:0] d,
                    input logic [3:0] b = 4'h1);
    @(negedge ref_clk_in);
    bar_hit_in = hit;
    wr_in = 1;
    addr_in = {hi, a};
    wdata_in = d;
    be_in = b;
    @(negedge ref_clk_in);
    wr_in = 0;
    bar_hit_in = 0;
  endtask

  task automatic rd(input logic [14:0] a, input logic [31:0] e,
                    input logic [31:0] m = '1);
    rq.push_back({m, e});
    @(negedge ref_clk_in);
    bar_hit_in = 1;
    rd_in = 1;
    addr_in = {hi, a};
    @(negedge ref_clk_in);
    rd_in = 0;
    bar_hit_in = 0;
    #1;
  endtask

  task automatic poll(input logic [14:0] a, input int b, input logic v);
    int k;
    k = 0;
    do begin
      rd(a, 32'h0, 32'h0);
      k++;
    end while (last_rd[b] !== v && k < 500);
    cmp({31'h0, last_rd[b]}, {31'h0, v}, "poll");
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Result monitor: every result takes the oldest note of its kind
  always @(negedge ref_clk_in) begin
    if (rd_valid_out) begin
      last_rd = rdata_out;
      if (rq.size() == 0) cmp(32'h1, 32'h0, "spurious read");
      else begin
        re = rq.pop_front();
        cmp(rdata_out & re[63:32], re[31:0] & re[63:32], "read data");
      end
    end
    if (flash_strobe_out) begin
      if (fq.size() == 0) cmp(32'h1, 32'h0, "spurious flash op");
      else cmp({flash_op_out, flash_addr_out, flash_wdata_out},
               fq.pop_front(), "flash op");
    end
    if (cfg_byte_valid_out) begin
      if (cq.size() == 0) cmp(32'h1, 32'h0, "spurious array byte");
      else cmp({23'h0, cfg_abort_out, cfg_byte_out},
               {23'h0, cq.pop_front()}, "array byte");
    end
  end

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      summarize();
    end
  end

  initial begin
    logic [20:0] fa;
    logic [7:0]  fd;
    logic [31:0] r;
    logic [14:0] ca [3];
    fcl_op_e     co [3];
    ca = '{OFS_FLASH_RESET, OFS_FLASH_SECT_ERS, OFS_FLASH_FULL_ERS};
    co = '{FCL_OP_RESET, FCL_OP_SECT, FCL_OP_CHIP};
    repeat (4) @(negedge ref_clk_in);
    srst_in = 0;
    rd(OFS_LOAD_STATUS, 32'h2);
    rd(OFS_FLASH_BUSY, 32'h80);
    hit = 0;
    wr(OFS_LOAD_CONTROL, 32'h1);
    hit = 1;
    rd(OFS_LOAD_CONTROL, 32'h0);
    poll(OFS_LOAD_STATUS, 0, 1'b1);
    rd(15'h3000, 32'h0);
    hi = 6'h1;
    rd(15'h0000, 32'h0);
    hi = 6'h0;
    wr(OFS_LOAD_CONTROL, 32'hffffff81, 4'hf);
    rd(15'h0fff, 32'h81);
    wr(OFS_LOAD_CONTROL, 32'h0, 4'he);
    rd(OFS_LOAD_CONTROL, 32'h81);
    cmp({31'h0, bus_hold_sel_out}, 32'h1, "hold select");
    rd(OFS_FLASH_BUSY, 32'h0);
    cmp({31'h0, autoload_en_out}, 32'h0, "autoload off");
    cmp({31'h0, eeprom_wr_en_out}, 32'h1, "eeprom open");
    tend("window");
    wr(OFS_LOAD_CONTROL, 32'h05);
    rd(OFS_LOAD_STATUS, 32'h0);
    poll(OFS_LOAD_STATUS, 1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      cq.push_back({1'b0, r[7:0]});
      wr(OFS_DIRECT_LOAD, {24'h0, r[7:0]});
      if (i == 2) rd(OFS_LOAD_STATUS, 32'h2);
    end
    rd(OFS_LOAD_STATUS, 32'h3);
    tend("direct");
    r = rnd();
    fa = {r[12:8], r[7:0], 8'hff};
    fd = r[31:24];
    wr(OFS_FLASH_WRITE, {24'h0, fd});
    wr(OFS_FLASH_ADDR_LOW, {24'h0, fa[7:0]});
    wr(OFS_FLASH_ADDR_MID, {24'h0, fa[15:8]});
    wr(OFS_FLASH_ADDR_HIGH, {27'h0, fa[20:16]});
    fq.push_back({FCL_OP_PROG, fa, fd});
    wr(OFS_FLASH_PROGRAM, 32'h1);
    rd(OFS_FLASH_BUSY, 32'h80);
    wr(OFS_FLASH_PROGRAM, 32'h1);
    wr(OFS_FLASH_FULL_ERS, 32'h1);
    poll(OFS_FLASH_BUSY, 7, 1'b0);
    fa = fa + 21'h1;
    fd = ~fd;
    wr(OFS_FLASH_WRITE, {24'h0, fd});
    fq.push_back({FCL_OP_PROG, fa, fd});
    wr(OFS_FLASH_PROGRAM, 32'h1);
    poll(OFS_FLASH_BUSY, 7, 1'b0);
    fa = fa + 21'h1;
    wr(OFS_FLASH_PROGRAM, 32'h2);
    fq.push_back({FCL_OP_READ, fa, fd});
    rd(OFS_FLASH_READ, {24'h0, fa[7:0] ^ 8'h5a});
    wp_in = 1;
    wr(OFS_FLASH_PROGRAM, 32'h1);
    wr(OFS_FLASH_SECT_ERS, 32'h1);
    rd(OFS_FLASH_BUSY, 32'h0);
    cmp({31'h0, eeprom_wr_en_out}, 32'h0, "eeprom locked");
    wp_in = 0;
    flash_dq5_in = 1;
    rd(OFS_FLASH_ERROR, 32'h20);
    flash_dq5_in = 0;
    wr(OFS_FLASH_ADDR_LOW, 32'h0);
    wr(OFS_FLASH_ADDR_MID, 32'h0);
    wr(OFS_FLASH_ADDR_HIGH, 32'h0);
    fq.push_back({FCL_OP_PROG, 21'h0, fd});
    wr(OFS_FLASH_PROGRAM, 32'h1);
    poll(OFS_FLASH_BUSY, 7, 1'b0);
    fa = 21'h1;
    for (int i = 0; i < 3; i++) begin
      fq.push_back({co[i], fa, fd});
      wr(ca[i], 32'h1);
      if (i == 2) begin
        repeat (60) @(negedge ref_clk_in);
        rd(OFS_FLASH_BUSY, 32'h80);
      end
      poll(OFS_FLASH_BUSY, 7, 1'b0);
    end
    tend("flash");
    wr(OFS_LOAD_CONTROL, 32'h05);
    poll(OFS_LOAD_STATUS, 1, 1'b1);
    wr(OFS_LOAD_CONTROL, 32'h0);
    rd(OFS_FLASH_BUSY, 32'h80);
    cmp({31'h0, autoload_en_out}, 32'h1, "autoload on");
    cq.push_back({1'b1, 8'h3c});
    wr(OFS_DIRECT_LOAD, 32'h3c);
    poll(OFS_LOAD_STATUS, 0, 1'b1);
    srst_in = 1;
    repeat (2) @(negedge ref_clk_in);
    srst_in = 0;
    rd(OFS_LOAD_STATUS, 32'h2);
    rd(OFS_LOAD_CONTROL, 32'h0);
    poll(OFS_LOAD_STATUS, 0, 1'b1);
    cmp(32'(rq.size() + fq.size() + cq.size()), 32'h0,
        "queues drained");
    tend("reload");
    summarize();
  end
endmodule
`default_nettype wire
